/* verilog/tsf_pkg.sv */
// Constants and carrier types for the trigger timestamp record formatter.
// Assumes byte addressing on a 32-bit classic Wishbone register bus.
package tsf_pkg;

  // Register byte addresses
  localparam logic [15:0] ADDR_COMMAND = 16'hb798;
  localparam logic [15:0] ADDR_CONTROL = 16'hb79c;
  localparam logic [15:0] ADDR_RATE = 16'hb7a0;
  localparam logic [15:0] ADDR_STATUS = 16'hb7a4;
  localparam logic [15:0] ADDR_COUNT_LO = 16'hb7a8;
  localparam logic [15:0] ADDR_COUNT_HI = 16'hb7ac;

  // Reset values
  localparam logic [31:0] COMMAND_RESET = 32'h0000_0000;
  localparam logic [15:0] RATE_RESET = 16'h0000;

  // Command register flag positions
  localparam int CMD_INPUT_CAPTURE_BIT = 12;
  localparam int CMD_SOURCE_CAPTURE_BIT = 19;

  // Control register bit positions
  localparam int CTRL_REFCLOCK_BIT = 0;
  localparam int CTRL_UPPER_GROUP_BIT = 1;
  localparam int CTRL_CLEAR_BIT = 2;

  // Status register bit positions
  localparam int STAT_OVERRUN_BIT = 0;
  localparam int STAT_EMPTY_BIT = 1;
  localparam int STAT_FULL_BIT = 2;
  localparam int STAT_LEVEL_LSB = 8;

  // Extra data word layout
  localparam int EXTRA_W = 40;
  localparam int SRC_ANALOG_LSB = 0;
  localparam int SRC_EXTERNAL0_BIT = 8;
  localparam int SRC_EXTERNAL1_BIT = 9;
  localparam int SRC_FORCED_BIT = 10;
  localparam int LOWER_LINES_LSB = 13;
  localparam int SRC_BACKPLANE_LSB = 16;
  localparam int SRC_STAR_BIT = 24;
  localparam int SRC_DIFF_STAR_BIT = 25;
  localparam int UPPER_LINES_LSB = 32;

  // Record layout
  localparam int WORD_W = 64;
  localparam int SHORT_COUNT_W = 40;
  localparam int REF_W = 24;
  localparam int FIFO_DEPTH = 32;

  // Sources that produced the final trigger
  typedef struct packed {
    logic diff_star;
    logic star;
    logic [7:0] backplane;
    logic forced;
    logic [1:0] external;
    logic [3:0] analog;
  } trig_src_t;

  // One timestamp record, lower word leaves first
  typedef struct packed {
    logic [63:0] upper;
    logic [63:0] lower;
  } record_t;

  typedef enum logic [2:0] {
    EMIT_IDLE = 3'b001,
    EMIT_LOW = 3'b010,
    EMIT_HIGH = 3'b100
  } emit_state_t;

endpackage

/* verilog/trigger_timestamp_record_formatter.sv */
// Trigger timestamp record formatter with its record FIFO.
// Assumes a single 25 MHz clock, a classic Wishbone master and an internal
// trigger pulse that is already synchronous to the clock.
`timescale 1ns/1ns

module record_fifo
#(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Words held in storage, output stage excluded
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int LEVEL_W = $clog2(DEPTH+1);

  // DEPTH must be a power of two so the pointers wrap on their own
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [LEVEL_W-1:0] count;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic push;
  logic pop;

  assign in_ready = (s.count != LEVEL_W'(DEPTH));
  assign out_valid = s.out_valid;
  assign out_data = s.out_data;
  assign level = s.count;

  always_comb
  begin
    next_s = s;
    push = in_valid && in_ready;
    // Output register refills whenever it is empty or being taken
    pop = (s.count != '0) && (!s.out_valid || out_ready);
    if (push)
    begin
      next_s.mem[s.wptr] = in_data;
      next_s.wptr = PTR_W'(s.wptr + 1'b1);
    end
    if (pop)
    begin
      next_s.out_data = s.mem[s.rptr];
      next_s.out_valid = 1'b1;
      next_s.rptr = PTR_W'(s.rptr + 1'b1);
    end
    else if (out_ready)
      next_s.out_valid = 1'b0;
    next_s.count = LEVEL_W'(s.count + LEVEL_W'(push) - LEVEL_W'(pop));
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

endmodule

module trigger_timestamp_record_formatter
#(
  parameter bit EXTRA_DIGITAL_IO_OPTION = 1'b1,
  parameter bit BACKPLANE_TRIGGERS = 1'b1,
  parameter int DEPTH = tsf_pkg::FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Internal trigger
  input wire logic trigger,
  input wire tsf_pkg::trig_src_t trigger_sources,
  // Pins
  input wire logic [2:0] lower_multipurpose_lines,
  input wire logic [7:0] upper_multipurpose_lines,
  input wire logic ref_clock_pin,
  // Record stream
  output logic record_valid,
  input wire logic record_ready,
  output logic [63:0] record_data
);

  localparam int LEVEL_W = $clog2(DEPTH+1);

  typedef struct packed {
    logic ack;
    logic [31:0] dat_o;
    logic [31:0] command;
    logic refclock_mode;
    logic upper_group;
    logic [15:0] rate;
    logic [15:0] div_count;
    logic overrun;
    logic [63:0] count;
    logic [23:0] ref_count;
    logic [10:0] lines_s1;
    logic [10:0] lines_s2;
    logic ref_s1;
    logic ref_s2;
    logic ref_prev;
    tsf_pkg::emit_state_t state;
    tsf_pkg::record_t record;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [63:0] fifo_in_data;
  logic [LEVEL_W-1:0] fifo_level;
  logic sample_tick;
  logic ref_edge;
  logic request;
  logic [31:0] status_word;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] sel);
    logic [31:0] result;
    result = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        result[8*i +: 8] = data[8*i +: 8];
      end
    end
    return result;
  endfunction

  function automatic logic hit(input logic [15:0] adr, input logic [15:0] reg_adr);
    return adr[15:2] == reg_adr[15:2];
  endfunction

  // Extra data word from the format flags, both may be set at once
  function automatic logic [39:0] build_extra(input logic [31:0] cmd, input logic upper_group,
                                              input logic [10:0] lines, input tsf_pkg::trig_src_t src);
    logic [39:0] extra;
    extra = '0;
    if (cmd[tsf_pkg::CMD_INPUT_CAPTURE_BIT])
    begin
      if (upper_group)
      begin
        if (EXTRA_DIGITAL_IO_OPTION)
        begin
          extra[tsf_pkg::UPPER_LINES_LSB +: 8] = lines[10:3];
        end
      end
      else
      begin
        extra[tsf_pkg::LOWER_LINES_LSB +: 3] = lines[2:0];
      end
    end
    if (cmd[tsf_pkg::CMD_SOURCE_CAPTURE_BIT])
    begin
      extra[tsf_pkg::SRC_ANALOG_LSB +: 4] = src.analog;
      extra[tsf_pkg::SRC_EXTERNAL0_BIT] = src.external[0];
      extra[tsf_pkg::SRC_EXTERNAL1_BIT] = src.external[1];
      extra[tsf_pkg::SRC_FORCED_BIT] = src.forced;
      if (BACKPLANE_TRIGGERS)
      begin
        extra[tsf_pkg::SRC_BACKPLANE_LSB +: 8] = src.backplane;
        extra[tsf_pkg::SRC_STAR_BIT] = src.star;
        extra[tsf_pkg::SRC_DIFF_STAR_BIT] = src.diff_star;
      end
    end
    return extra;
  endfunction

  // Lower word: plain counter, or short counter under a reference count
  function automatic logic [63:0] build_lower(input logic refclock_mode, input logic [23:0] ref_count,
                                              input logic [63:0] count);
    logic [63:0] lower;
    lower = count;
    if (refclock_mode)
    begin
      lower = {ref_count, count[tsf_pkg::SHORT_COUNT_W-1:0]};
    end
    return lower;
  endfunction

  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat_o;

  always_comb
  begin
    status_word = '0;
    status_word[tsf_pkg::STAT_OVERRUN_BIT] = s.overrun;
    status_word[tsf_pkg::STAT_EMPTY_BIT] = (fifo_level == '0) && !record_valid;
    status_word[tsf_pkg::STAT_FULL_BIT] = !fifo_in_ready;
    status_word[tsf_pkg::STAT_LEVEL_LSB +: LEVEL_W] = fifo_level;
  end

  // Lower word leaves before upper word of the same record
  always_comb
  begin
    fifo_in_valid = (s.state == tsf_pkg::EMIT_LOW) || (s.state == tsf_pkg::EMIT_HIGH);
    fifo_in_data = (s.state == tsf_pkg::EMIT_HIGH) ? s.record.upper : s.record.lower;
  end

  always_comb
  begin
    next_s = s;
    next_s.ack = 1'b0;

    // Two-stage synchronisers for the pins
    next_s.lines_s1 = {upper_multipurpose_lines, lower_multipurpose_lines};
    next_s.lines_s2 = s.lines_s1;
    next_s.ref_s1 = ref_clock_pin;
    next_s.ref_s2 = s.ref_s1;
    next_s.ref_prev = s.ref_s2;
    ref_edge = s.ref_s2 && !s.ref_prev;

    // Sample-rate enable from the divider
    sample_tick = (s.div_count >= s.rate);
    next_s.div_count = sample_tick ? 16'h0000 : 16'(s.div_count + 16'h0001);
    if (sample_tick)
      next_s.count = 64'(s.count + 64'h1);

    // In refclock mode the short count restarts on each reference edge
    if (s.refclock_mode && ref_edge)
    begin
      next_s.ref_count = 24'(s.ref_count + 24'h1);
      next_s.count = '0;
    end

    // Record emission, stalled by a full FIFO
    request = wb_cyc_i && wb_stb_i && !s.ack;
    unique case (s.state)
      tsf_pkg::EMIT_IDLE:
        next_s.state = tsf_pkg::EMIT_IDLE;
      tsf_pkg::EMIT_LOW:
        if (fifo_in_ready)
          next_s.state = tsf_pkg::EMIT_HIGH;
      tsf_pkg::EMIT_HIGH:
        if (fifo_in_ready)
          next_s.state = tsf_pkg::EMIT_IDLE;
      default:
        next_s.state = tsf_pkg::EMIT_IDLE;
    endcase

    // Register access, answered one cycle after the request
    if (request)
    begin
      next_s.ack = 1'b1;
      next_s.dat_o = '0;
      if (wb_we_i)
      begin
        if (hit(wb_adr_i, tsf_pkg::ADDR_COMMAND))
          next_s.command = merge_bytes(s.command, wb_dat_i, wb_sel_i);
        else if (hit(wb_adr_i, tsf_pkg::ADDR_CONTROL) && wb_sel_i[0])
        begin
          next_s.refclock_mode = wb_dat_i[tsf_pkg::CTRL_REFCLOCK_BIT];
          next_s.upper_group = wb_dat_i[tsf_pkg::CTRL_UPPER_GROUP_BIT];
          if (wb_dat_i[tsf_pkg::CTRL_CLEAR_BIT])
          begin
            next_s.count = '0;
            next_s.ref_count = '0;
            next_s.div_count = '0;
          end
        end
        else if (hit(wb_adr_i, tsf_pkg::ADDR_RATE))
          next_s.rate = 16'(merge_bytes({16'h0000, s.rate}, wb_dat_i, wb_sel_i));
        else if (hit(wb_adr_i, tsf_pkg::ADDR_STATUS) && wb_sel_i[0])
        begin
          // Write one to clear; a new overrun below still wins
          if (wb_dat_i[tsf_pkg::STAT_OVERRUN_BIT])
          begin
            next_s.overrun = 1'b0;
          end
        end
      end
      else
      begin
        if (hit(wb_adr_i, tsf_pkg::ADDR_COMMAND))
          next_s.dat_o = s.command;
        else if (hit(wb_adr_i, tsf_pkg::ADDR_CONTROL))
        begin
          next_s.dat_o[tsf_pkg::CTRL_REFCLOCK_BIT] = s.refclock_mode;
          next_s.dat_o[tsf_pkg::CTRL_UPPER_GROUP_BIT] = s.upper_group;
        end
        else if (hit(wb_adr_i, tsf_pkg::ADDR_RATE))
          next_s.dat_o = {16'h0000, s.rate};
        else if (hit(wb_adr_i, tsf_pkg::ADDR_STATUS))
          next_s.dat_o = status_word;
        // Halves are read separately and may tear while counting
        else if (hit(wb_adr_i, tsf_pkg::ADDR_COUNT_LO))
          next_s.dat_o = s.count[31:0];
        else if (hit(wb_adr_i, tsf_pkg::ADDR_COUNT_HI))
          next_s.dat_o = s.count[63:32];
      end
    end

    // Capture uses the counter as it stands in the trigger cycle, so the
    // delay from the external edge is the same for every recording
    if (trigger)
    begin
      if (s.state == tsf_pkg::EMIT_IDLE)
      begin
        next_s.record.lower = build_lower(s.refclock_mode, s.ref_count, s.count);
        next_s.record.upper = {24'h000000, build_extra(s.command, s.upper_group,
                                                       s.lines_s2, trigger_sources)};
        next_s.state = tsf_pkg::EMIT_LOW;
      end
      else
      begin
        // A record in flight cannot be overwritten; the trigger is dropped
        next_s.overrun = 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.command <= tsf_pkg::COMMAND_RESET;
      s.rate <= tsf_pkg::RATE_RESET;
      s.state <= tsf_pkg::EMIT_IDLE;
    end
    else
      s <= next_s;
  end

  record_fifo
  #(
    .WIDTH(tsf_pkg::WORD_W),
    .DEPTH(DEPTH)
  )
  u_fifo
  (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(record_valid),
    .out_ready(record_ready),
    .out_data(record_data),
    .level(fifo_level)
  );

endmodule

/* testbench/tsf_chk.sv */
// Port assertions for the timestamp record formatter, bound to its top.
// Assumes command and group change only while the record stream is empty.
`timescale 1ns/1ns
module tsf_chk
#(
  parameter bit EXTRA_DIGITAL_IO_OPTION = 1'b1,
  parameter bit BACKPLANE_TRIGGERS = 1'b1,
  parameter int DEPTH = 32
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Trigger and stream
  input wire logic trigger,
  input wire logic record_valid,
  input wire logic record_ready,
  input wire logic [63:0] record_data
);
  logic [31:0] cmd;
  logic grp;
  logic hi;
  // Shadows of the format, tracked from acked writes; hi tracks the word parity from stream handshakes
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cmd <= 32'h0;
      grp <= 1'b0;
      hi <= 1'b0;
    end
    else
    begin
      if (wb_ack_o && wb_we_i && wb_adr_i == tsf_pkg::ADDR_COMMAND)
        cmd <= wb_dat_i;
      if (wb_ack_o && wb_we_i && wb_adr_i == tsf_pkg::ADDR_CONTROL)
        grp <= wb_dat_i[tsf_pkg::CTRL_UPPER_GROUP_BIT];
      if (record_valid && record_ready)
        hi <= !hi;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_on_request: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  a_ack_needs_request: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_record_holds: assert property (record_valid && !record_ready |=> record_valid && $stable(record_data))
    else $error("record word changed while stalled");
  a_trigger_latency: assert property (trigger && !record_valid && !$past(trigger) && !$past(trigger, 2)
    |-> ##[2:3] record_valid) else $error("record late after trigger");
  a_upper_pad_zero: assert property (record_valid && hi |-> record_data[63:40] == 24'h0
    && record_data[31:26] == 6'h0 && record_data[12:11] == 2'h0 && record_data[7:4] == 4'h0)
    else $error("upper word padding set");
  a_lines_off: assert property (record_valid && hi && !cmd[12]
    |-> record_data[39:32] == 8'h0 && record_data[15:13] == 3'h0) else $error("lines without flag");
  a_sources_off: assert property (record_valid && hi && !cmd[19]
    |-> record_data[25:16] == 10'h0 && record_data[10:0] == 11'h0) else $error("sources without flag");
  a_group_select: assert property (record_valid && hi
    |-> (grp ? record_data[15:13] == 3'h0 : record_data[39:32] == 8'h0)) else $error("inactive group set");
  c_trigger: cover property (trigger);
  c_upper_taken: cover property (record_valid && record_ready && hi);
  c_write: cover property (wb_ack_o && wb_we_i);
endmodule

bind trigger_timestamp_record_formatter tsf_chk #(.EXTRA_DIGITAL_IO_OPTION(EXTRA_DIGITAL_IO_OPTION),
  .BACKPLANE_TRIGGERS(BACKPLANE_TRIGGERS), .DEPTH(DEPTH)) u_chk (.clock(clock), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .trigger(trigger), .record_valid(record_valid), .record_ready(record_ready),
  .record_data(record_data));

/* testbench/host_reader.sv */
// Host reader model: takes record words off the stream into a queue.
// Assumes the bench pops the queue and raises hold to stall the stream.
`timescale 1ns/1ns
module host_reader
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Record stream
  input wire logic record_valid,
  input wire logic [63:0] record_data,
  output logic record_ready,
  // Bench control
  input wire logic hold
);
  logic [63:0] words[$];
  // Kept in arrival order, so pairs stay lower word first
  always @(posedge clock)
  begin
    if (!rst_n)
      record_ready <= 1'b0;
    else
      record_ready <= !hold;
    if (rst_n && record_valid && record_ready)
      words.push_back(record_data);
  end
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the timestamp record formatter.
// Assumes the host model pops nothing itself; the bench drains its queue.
`timescale 1ns/1ns
module tb_top;
  logic clock, rst_n, cyc, stb, we, trig, refp, hold, ack, valid, ready;
  logic [15:0] adr;
  logic [31:0] wdat, rdat, q, c;
  logic [2:0] lo;
  logic [7:0] up;
  logic [63:0] data, w0, w1, w2, w3;
  tsf_pkg::trig_src_t src;
  int failures, samples_checked;
  typedef struct packed {
    logic [1:0] f;
    logic g;
    tsf_pkg::trig_src_t s;
    logic [2:0] lo;
    logic [7:0] up;
    logic [39:0] x;
  } row_t;
  row_t rows [7] = '{
    '{2'h0, 1'h0, 17'h1ffff, 3'h7, 8'hff, 40'h0},
    '{2'h1, 1'h0, 17'h1ffff, 3'h5, 8'hff, 40'ha000},
    '{2'h1, 1'h1, 17'h1ffff, 3'h7, 8'ha5, 40'ha5_0000_0000},
    '{2'h2, 1'h0, 17'h00069, 3'h7, 8'hff, 40'h609},
    '{2'h2, 1'h1, 17'h0c096, 3'h7, 8'hff, 40'h181_0106},
    '{2'h3, 1'h1, 17'h10000, 3'h7, 8'h3c, 40'h3c_0200_0000},
    '{2'h3, 1'h0, 17'h0000f, 3'h3, 8'hff, 40'h600f}};

  trigger_timestamp_record_formatter u_dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .trigger(trig), .trigger_sources(src), .lower_multipurpose_lines(lo), .upper_multipurpose_lines(up),
    .ref_clock_pin(refp), .record_valid(valid), .record_ready(ready), .record_data(data));
  host_reader u_host (.clock(clock), .rst_n(rst_n), .record_valid(valid), .record_data(data),
    .record_ready(ready), .hold(hold));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clock);
    while (ack !== 1'b1 && n < 50)
    begin
      @(posedge clock);
      n++;
    end
    q = rdat;
    if (n >= 50)
      failures++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask

  task automatic fire(input tsf_pkg::trig_src_t s, input int gap);
    trig <= 1'b1;
    src <= s;
    @(posedge clock);
    trig <= 1'b0;
    repeat (gap - 1) @(posedge clock);
  endtask

  task automatic take(output logic [63:0] a, output logic [63:0] b);
    int n;
    n = 0;
    while (u_host.words.size() < 2 && n < 300)
    begin
      @(posedge clock);
      n++;
    end
    a = 64'h0;
    b = 64'h0;
    if (u_host.words.size() < 2)
      failures++;
    else
    begin
      a = u_host.words.pop_front();
      b = u_host.words.pop_front();
    end
  endtask

  task automatic pulse_ref();
    refp <= 1'b1;
    repeat (3) @(posedge clock);
    refp <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
  endtask

  task automatic report_and_stop();
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog sized well above the full sequence
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    report_and_stop();
  end

  initial
  begin
    failures = 0;
    samples_checked = 0;
    {rst_n, cyc, stb, we, trig, refp, hold} = 7'h0;
    {adr, wdat, lo, up, src} = '0;
    do_reset();
    check({62'h0, ack, valid}, 64'h0);
    bus(1'b0, tsf_pkg::ADDR_COMMAND, 32'h0);
    check(64'(q), 64'(tsf_pkg::COMMAND_RESET));
    bus(1'b0, tsf_pkg::ADDR_STATUS, 32'h0);
    check(64'(q), 64'h2);
    bus(1'b0, tsf_pkg::ADDR_COUNT_HI, 32'h0);
    check(64'(q), 64'h0);
    bus(1'b0, 16'h0100, 32'h0);
    check(64'(q), 64'h0);
    foreach (rows[i])
    begin
      c = 32'h0;
      c[tsf_pkg::CMD_INPUT_CAPTURE_BIT] = rows[i].f[0];
      c[tsf_pkg::CMD_SOURCE_CAPTURE_BIT] = rows[i].f[1];
      bus(1'b1, tsf_pkg::ADDR_COMMAND, c);
      bus(1'b0, tsf_pkg::ADDR_COMMAND, 32'h0);
      check(64'(q), 64'(c));
      bus(1'b1, tsf_pkg::ADDR_CONTROL, {30'h0, rows[i].g, 1'b0});
      lo <= rows[i].lo;
      up <= rows[i].up;
      repeat (4) @(posedge clock);
      fire(rows[i].s, 4);
      take(w0, w1);
      check(w1, {24'h0, rows[i].x});
    end
    bus(1'b1, tsf_pkg::ADDR_COMMAND, 32'h0);
    // Counter advance over a 20-cycle trigger gap at two divider settings
    for (int r = 0; r < 4; r += 3)
    begin
      bus(1'b1, tsf_pkg::ADDR_RATE, 32'(r));
      bus(1'b1, tsf_pkg::ADDR_CONTROL, 32'h4);
      bus(1'b0, tsf_pkg::ADDR_COUNT_LO, 32'h0);
      check(64'(q), 64'(2 / (r + 1)));
      fire('0, 20);
      fire('0, 4);
      take(w0, w1);
      take(w2, w3);
      check({63'h0, w0 < 64'd8}, 64'h1);
      check(w2 - w0, 64'(20 / (r + 1)));
    end
    bus(1'b1, tsf_pkg::ADDR_RATE, 32'h0);
    bus(1'b1, tsf_pkg::ADDR_CONTROL, 32'h5);
    pulse_ref();
    pulse_ref();
    fire('0, 12);
    fire('0, 4);
    take(w0, w1);
    take(w2, w3);
    check(64'(w2[39:0] - w0[39:0]), 64'd12);
    check(64'(w2[63:40]), 64'(w0[63:40]));
    pulse_ref();
    fire('0, 4);
    take(w2, w3);
    check(64'(w2[63:40]), 64'(w0[63:40] + 24'h1));
    bus(1'b1, tsf_pkg::ADDR_CONTROL, 32'h0);
    // Stall the host so the buffer fills and a trigger is dropped
    hold <= 1'b1;
    repeat (18) fire('0, 4);
    bus(1'b0, tsf_pkg::ADDR_STATUS, 32'h0);
    check(64'(q[2:0]), 64'h5);
    hold <= 1'b0;
    repeat (100) @(posedge clock);
    check(64'(u_host.words.size()), 64'd34);
    for (int k = 0; k + 2 < u_host.words.size(); k += 2)
      check({63'h0, u_host.words[k + 2] > u_host.words[k]}, 64'h1);
    u_host.words.delete();
    bus(1'b0, tsf_pkg::ADDR_STATUS, 32'h0);
    check(64'(q[2:0]), 64'h3);
    bus(1'b1, tsf_pkg::ADDR_STATUS, 32'h1);
    bus(1'b0, tsf_pkg::ADDR_STATUS, 32'h0);
    check(64'(q[2:0]), 64'h2);
    bus(1'b1, tsf_pkg::ADDR_COMMAND, 32'h81000);
    do_reset();
    check({62'h0, ack, valid}, 64'h0);
    bus(1'b0, tsf_pkg::ADDR_COMMAND, 32'h0);
    check(64'(q), 64'(tsf_pkg::COMMAND_RESET));
    report_and_stop();
  end
endmodule
